// File: mtdp_defines.svh
// Register offsets, field positions, reset values and timing counts for the data move timing block
`ifndef MTDP_DEFINES_SVH
`define MTDP_DEFINES_SVH

`define MTDP_ADDR_PTR_SELECT   8'h86
`define MTDP_ADDR_CLOCK_CTRL   8'h8e
`define MTDP_ADDR_PRI_LOW      8'h82
`define MTDP_ADDR_PRI_HIGH     8'h83
`define MTDP_SEL_BIT           0
`define MTDP_STRETCH_MSB       2
`define MTDP_STRETCH_LSB       0
`define MTDP_STRETCH_RESET     3'h1
`define MTDP_CLOCK_CTRL_RESET  8'h01
`define MTDP_XMOVE_BASE_CYCLES 4'h2
`define MTDP_MIN_CYCLES        3'h1
`define MTDP_MAX_CYCLES        3'h5
`define MTDP_STATES_PER_CYCLE  4

`endif

// File: mtdp_pkg.sv
// Types shared by the data move timing block and its users
package mtdp_pkg;

	typedef enum logic [1:0] {
		MTDP_STATE_ONE   = 2'b00,
		MTDP_STATE_TWO   = 2'b01,
		MTDP_STATE_THREE = 2'b10,
		MTDP_STATE_FOUR  = 2'b11
	} mtdp_state_t;

	// One instruction as presented by the core
	typedef struct packed {
		logic       valid;
		logic [2:0] cycles;
		logic       is_xmove;
		logic       ptr_form;
		logic       write;
		logic [7:0] indir_low;
		logic [7:0] port2_latch;
	} mtdp_instr_t;

	// Special function register access port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       inc;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mtdp_sfr_req_t;

endpackage

// File: mtdp_external_data_move_timing.sv
// Machine cycle sequencer, stretched external data move and dual data pointers
`timescale 1ns/1ps
`include "mtdp_defines.svh"

module mtdp_external_data_move_timing (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire mtdp_pkg::mtdp_instr_t  instr,
	input  wire logic                   ptr_inc,
	input  wire mtdp_pkg::mtdp_sfr_req_t sfr_req,
	output logic [7:0]                  sfr_rdata,
	output mtdp_pkg::mtdp_state_t       state,
	output logic                        half,
	output logic                        instr_take,
	output logic                        opcode_fetch,
	output logic [3:0]                  mcycle,
	output logic [15:0]                 ext_addr,
	output logic                        read_strobe_n,
	output logic                        write_strobe_n
);
	import mtdp_pkg::*;

	logic        pointer_select;
	logic [2:0]  stretch_field;
	logic [15:0] primary_data_pointer;
	logic [15:0] secondary_data_pointer;
	logic [3:0]  total;
	logic        is_xmove;
	logic        is_write;

	mtdp_state_t next_state;
	logic        next_half;
	logic        next_instr_take;
	logic        next_opcode_fetch;
	logic [3:0]  next_mcycle;
	logic [3:0]  next_total;
	logic        next_is_xmove;
	logic        next_is_write;
	logic [15:0] next_ext_addr;
	logic        next_read_strobe_n;
	logic        next_write_strobe_n;

	logic        next_pointer_select;
	logic [2:0]  next_stretch_field;
	logic [15:0] next_primary_data_pointer;
	logic [15:0] next_secondary_data_pointer;
	logic [7:0]  next_sfr_rdata;

	logic        end_of_mcycle;
	logic        end_of_instr;
	logic [15:0] selected_ptr;

	// Clamp a requested cycle count into the one-to-five range
	function automatic logic [3:0] clamp_cycles(input logic [2:0] c);
		logic [2:0] r;
		r = c;
		if (c < `MTDP_MIN_CYCLES)
			r = `MTDP_MIN_CYCLES;
		else if (c > `MTDP_MAX_CYCLES)
			r = `MTDP_MAX_CYCLES;
		return {1'b0, r};
	endfunction

	// Strobe window: from state two of the second cycle to state three of the last
	function automatic logic strobe_on(input logic [3:0] mc, input logic [3:0] tot,
		input mtdp_state_t st);
		logic on;
		on = 1'b0;
		if (mc == 4'h1 && st != MTDP_STATE_ONE)
			on = 1'b1;
		else if (mc > 4'h1)
			on = 1'b1;
		if (mc == tot - 4'h1 && st == MTDP_STATE_FOUR)
			on = 1'b0;
		return on;
	endfunction

	assign selected_ptr  = pointer_select ? secondary_data_pointer : primary_data_pointer;
	assign end_of_mcycle = (state == MTDP_STATE_FOUR) && half;
	assign end_of_instr  = end_of_mcycle && (mcycle == total - 4'h1);

	// Sequencer
	always_comb begin
		next_state          = state;
		next_half           = ~half;
		next_mcycle         = mcycle;
		next_total          = total;
		next_is_xmove       = is_xmove;
		next_is_write       = is_write;
		next_ext_addr       = ext_addr;
		next_instr_take     = 1'b0;
		next_opcode_fetch   = 1'b0;
		if (half) begin
			case (state)
				MTDP_STATE_ONE:   next_state = MTDP_STATE_TWO;
				MTDP_STATE_TWO:   next_state = MTDP_STATE_THREE;
				MTDP_STATE_THREE: next_state = MTDP_STATE_FOUR;
				MTDP_STATE_FOUR:  next_state = MTDP_STATE_ONE;
				default:          next_state = MTDP_STATE_ONE;
			endcase
		end
		if (end_of_instr) begin
			next_mcycle     = 4'h0;
			next_instr_take = 1'b1;
			if (instr.valid && instr.is_xmove) begin
				next_total    = `MTDP_XMOVE_BASE_CYCLES + {1'b0, stretch_field};
				next_is_xmove = 1'b1;
				next_is_write = instr.write;
				if (instr.ptr_form)
					next_ext_addr = selected_ptr;
				else
					next_ext_addr = {instr.port2_latch, instr.indir_low};
			end else if (instr.valid) begin
				next_total    = clamp_cycles(instr.cycles);
				next_is_xmove = 1'b0;
				next_is_write = 1'b0;
			end else begin
				next_total    = 4'h1;
				next_is_xmove = 1'b0;
				next_is_write = 1'b0;
			end
		end else if (end_of_mcycle) begin
			next_mcycle = mcycle + 4'h1;
		end
		// Stretched access cycles of a data move fetch nothing
		if (next_state == MTDP_STATE_ONE && !next_half && end_of_mcycle &&
			(!next_is_xmove || next_mcycle == 4'h0))
			next_opcode_fetch = 1'b1;
		next_read_strobe_n  = 1'b1;
		next_write_strobe_n = 1'b1;
		if (next_is_xmove && strobe_on(next_mcycle, next_total, next_state)) begin
			next_read_strobe_n  = next_is_write;
			next_write_strobe_n = ~next_is_write;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state          <= MTDP_STATE_ONE;
			half           <= 1'b0;
			mcycle         <= 4'h0;
			total          <= 4'h1;
			is_xmove       <= 1'b0;
			is_write       <= 1'b0;
			ext_addr       <= 16'h0000;
			instr_take     <= 1'b0;
			opcode_fetch   <= 1'b1;
			read_strobe_n  <= 1'b1;
			write_strobe_n <= 1'b1;
		end else begin
			state          <= next_state;
			half           <= next_half;
			mcycle         <= next_mcycle;
			total          <= next_total;
			is_xmove       <= next_is_xmove;
			is_write       <= next_is_write;
			ext_addr       <= next_ext_addr;
			instr_take     <= next_instr_take;
			opcode_fetch   <= next_opcode_fetch;
			read_strobe_n  <= next_read_strobe_n;
			write_strobe_n <= next_write_strobe_n;
		end
	end

	// Special function registers and pointers
	always_comb begin
		next_pointer_select         = pointer_select;
		next_stretch_field          = stretch_field;
		next_primary_data_pointer   = primary_data_pointer;
		next_secondary_data_pointer = secondary_data_pointer;
		next_sfr_rdata              = sfr_rdata;
		if (ptr_inc) begin
			if (pointer_select)
				next_secondary_data_pointer = secondary_data_pointer + 16'h0001;
			else
				next_primary_data_pointer = primary_data_pointer + 16'h0001;
		end
		if (sfr_req.inc && sfr_req.addr == `MTDP_ADDR_PTR_SELECT)
			next_pointer_select = ~pointer_select;
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				`MTDP_ADDR_PTR_SELECT:
					next_pointer_select = sfr_req.wdata[`MTDP_SEL_BIT];
				`MTDP_ADDR_CLOCK_CTRL:
					next_stretch_field = sfr_req.wdata[`MTDP_STRETCH_MSB:`MTDP_STRETCH_LSB];
				`MTDP_ADDR_PRI_LOW: begin
					if (pointer_select)
						next_secondary_data_pointer[7:0] = sfr_req.wdata;
					else
						next_primary_data_pointer[7:0] = sfr_req.wdata;
				end
				`MTDP_ADDR_PRI_HIGH: begin
					if (pointer_select)
						next_secondary_data_pointer[15:8] = sfr_req.wdata;
					else
						next_primary_data_pointer[15:8] = sfr_req.wdata;
				end
				default: ;
			endcase
		end
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`MTDP_ADDR_PTR_SELECT: next_sfr_rdata = {7'h00, pointer_select};
				`MTDP_ADDR_CLOCK_CTRL: next_sfr_rdata = {5'h00, stretch_field};
				`MTDP_ADDR_PRI_LOW:    next_sfr_rdata = selected_ptr[7:0];
				`MTDP_ADDR_PRI_HIGH:   next_sfr_rdata = selected_ptr[15:8];
				default:               next_sfr_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pointer_select         <= 1'b0;
			stretch_field          <= `MTDP_STRETCH_RESET;
			primary_data_pointer   <= 16'h0000;
			secondary_data_pointer <= 16'h0000;
			sfr_rdata              <= 8'h00;
		end else begin
			pointer_select         <= next_pointer_select;
			stretch_field          <= next_stretch_field;
			primary_data_pointer   <= next_primary_data_pointer;
			secondary_data_pointer <= next_secondary_data_pointer;
			sfr_rdata              <= next_sfr_rdata;
		end
	end

endmodule

// File: mtdp_external_data_move_timing_asserts.sv
// Port-level assertions for the data move timing block
`timescale 1ns/1ps
`include "mtdp_defines.svh"
module mtdp_external_data_move_timing_asserts (
	input wire logic                    clk,
	input wire logic                    reset,
	input wire mtdp_pkg::mtdp_sfr_req_t sfr_req,
	input wire logic [7:0]              sfr_rdata,
	input wire mtdp_pkg::mtdp_state_t   state,
	input wire logic                    half,
	input wire logic                    instr_take,
	input wire logic                    opcode_fetch,
	input wire logic [3:0]              mcycle,
	input wire logic [15:0]             ext_addr,
	input wire logic                    read_strobe_n,
	input wire logic                    write_strobe_n
);
	import mtdp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_low4;
		(!read_strobe_n)[*4];
	endsequence
	state_order_a: assert property (half |=> state == 2'($past(state) + 2'h1))
		else $error("state order broken");
	half_pair_a: assert property (!half |=> half && $stable(state))
		else $error("state half sequence broken");
	take_start_a: assert property (instr_take |-> opcode_fetch && state == MTDP_STATE_ONE
		&& !half && mcycle == 4'h0)
		else $error("instruction start misplaced");
	fetch_phase_a: assert property (opcode_fetch |-> state == MTDP_STATE_ONE && !half)
		else $error("fetch outside state one");
	strobe_one_a: assert property (read_strobe_n || write_strobe_n)
		else $error("both strobes low");
	strobe_start_a: assert property ($fell(read_strobe_n) || $fell(write_strobe_n)
		|-> mcycle == 4'h1 && state == MTDP_STATE_TWO && !half)
		else $error("strobe starts at wrong state");
	strobe_min_a: assert property ($fell(read_strobe_n) |-> s_low4)
		else $error("read strobe too short");
	addr_hold_a: assert property (!read_strobe_n && !$past(read_strobe_n)
		|-> $stable(ext_addr))
		else $error("address moved under strobe");
	move_no_fetch_a: assert property (!(read_strobe_n && write_strobe_n) |-> !opcode_fetch)
		else $error("fetch during data access");
	sel_read_a: assert property ($past(sfr_req.rd) &&
		$past(sfr_req.addr) == `MTDP_ADDR_PTR_SELECT |-> sfr_rdata[7:1] == 7'h0)
		else $error("select upper bits not zero");
endmodule

bind mtdp_external_data_move_timing mtdp_external_data_move_timing_asserts u_chk (.clk(clk), .reset(reset),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .state(state), .half(half),
	.instr_take(instr_take), .opcode_fetch(opcode_fetch), .mcycle(mcycle),
	.ext_addr(ext_addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));

// File: mtdp_ext_mem.sv
// External data space model that logs each strobe window
`timescale 1ns/1ps
module mtdp_ext_mem (
	input  wire logic        clk,
	input  wire logic [15:0] ext_addr,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	output logic [15:0]      last_addr,
	output logic [7:0]       last_width,
	output logic             last_wr
);
	logic [7:0] cnt = 8'h0;
	always @(posedge clk) begin
		if (!read_strobe_n || !write_strobe_n) begin
			if (cnt == 8'h0) begin
				last_addr <= ext_addr;
				last_wr   <= !write_strobe_n;
			end
			cnt <= cnt + 8'h1;
		end else if (cnt != 8'h0) begin
			last_width <= cnt;
			cnt        <= 8'h0;
		end
	end
endmodule

// File: mtdp_external_data_move_timing_tb.sv
// Self-checking bench for the data move timing block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module mtdp_external_data_move_timing_tb;
	import mtdp_pkg::*;
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	mtdp_instr_t   instr = '0;
	logic          ptr_inc = 1'b0;
	mtdp_sfr_req_t sfr_req = '0;
	logic [7:0]    sfr_rdata;
	mtdp_state_t   state;
	logic          half, instr_take, opcode_fetch, read_strobe_n, write_strobe_n;
	logic [3:0]    mcycle;
	logic [15:0]   ext_addr, last_addr;
	logic [7:0]    last_width;
	logic          last_wr;
	int            error_cnt = 0;
	int            checks_done = 0;
	int            cyc = 0;
	int            dur = 0;
	longint        t_take = 0;
	int            fetch_cnt = 0;
	int            fetch_mark = 0;
	int            fetches = 0;
	mtdp_external_data_move_timing uut (.clk(clk), .reset(reset), .instr(instr), .ptr_inc(ptr_inc),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .state(state), .half(half),
		.instr_take(instr_take), .opcode_fetch(opcode_fetch), .mcycle(mcycle),
		.ext_addr(ext_addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
	mtdp_ext_mem u_mem (.clk(clk), .ext_addr(ext_addr), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .last_addr(last_addr), .last_width(last_width),
		.last_wr(last_wr));
	initial begin
		forever #50 clk = ~clk;
	end
	task complete_run();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (opcode_fetch === 1'b1)
			fetch_cnt <= fetch_cnt + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end
	task sfr(input logic w, input logic r, input logic i, input logic [7:0] a,
		input logic [7:0] d);
		sfr_req = '{w, r, i, a, d};
		@(negedge clk);
		sfr_req = '0;
		@(negedge clk);
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		sfr(1'b0, 1'b1, 1'b0, a, 8'h00);
		`CHK(sfr_rdata, e)
	endtask
	// Returns at the take pulse; dur and fetches describe the previous instruction
	task issue(input mtdp_instr_t x);
		int n;
		instr = x;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (instr_take !== 1'b1 && n < 300);
		if (n >= 300)
			error_cnt++;
		dur = int'(($time - t_take) / 100);
		t_take = $time;
		fetches = fetch_cnt - fetch_mark;
		fetch_mark = fetch_cnt;
	endtask
	task op(input logic [2:0] c, input logic mv, input logic pf, input logic wr,
		input logic [15:0] ea, input int em, input logic [7:0] w);
		issue('{1'b1, c, mv, pf, wr, pf ? ~ea[7:0] : ea[7:0], pf ? ~ea[15:8] : ea[15:8]});
		issue('0);
		`CHK(dur, 8 * em)
		`CHK(fetches, mv ? 1 : em)
		if (mv) begin
			`CHK(last_width, w)
			`CHK(last_addr, ea)
			`CHK(last_wr, wr)
		end
	endtask
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		rd_chk(8'h86, 8'h00);
		rd_chk(8'h8e, 8'h01);
		rd_chk(8'h90, 8'h00);
		sfr(1'b1, 1'b0, 1'b0, 8'h86, 8'hfe);
		rd_chk(8'h86, 8'h00);
		sfr(1'b1, 1'b0, 1'b0, 8'h86, 8'hff);
		rd_chk(8'h86, 8'h01);
		sfr(1'b0, 1'b0, 1'b1, 8'h86, 8'h00);
		rd_chk(8'h86, 8'h00);
		sfr(1'b1, 1'b0, 1'b0, 8'h82, 8'h34);
		sfr(1'b1, 1'b0, 1'b0, 8'h83, 8'h12);
		sfr(1'b0, 1'b0, 1'b1, 8'h86, 8'h00);
		sfr(1'b1, 1'b0, 1'b0, 8'h82, 8'hcd);
		sfr(1'b1, 1'b0, 1'b0, 8'h83, 8'hab);
		for (int i = 1; i <= 5; i++)
			op(3'(i), 1'b0, 1'b0, 1'b0, 16'h0, i, 8'h0);
		op(3'h0, 1'b0, 1'b0, 1'b0, 16'h0, 1, 8'h0);
		op(3'h7, 1'b0, 1'b0, 1'b0, 16'h0, 5, 8'h0);
		op(3'h2, 1'b1, 1'b0, 1'b0, 16'hc35a, 3, 8'h0c);
		sfr(1'b1, 1'b0, 1'b0, 8'h8e, 8'h00);
		op(3'h2, 1'b1, 1'b1, 1'b1, 16'habcd, 2, 8'h04);
		sfr(1'b1, 1'b0, 1'b0, 8'h8e, 8'hff);
		rd_chk(8'h8e, 8'h07);
		sfr(1'b0, 1'b0, 1'b1, 8'h86, 8'h00);
		op(3'h2, 1'b1, 1'b1, 1'b0, 16'h1234, 9, 8'h3c);
		op(3'h3, 1'b0, 1'b0, 1'b0, 16'h0, 3, 8'h0);
		ptr_inc = 1'b1;
		@(negedge clk);
		ptr_inc = 1'b0;
		rd_chk(8'h82, 8'h35);
		rd_chk(8'h83, 8'h12);
		complete_run();
	end
endmodule
